// ===== core/cvc_cmp_chan.v
`timescale 1ns/1ps
`include "cvc_regs.vh"

// One comparator channel: synchroniser, polarity, edge event
module cvc_cmp_chan (
	input wire clk, // System clock
	input wire rst_n, // Async reset, active low
	input wire raw_in, // Analog comparator output, async
	input wire cmp_on, // Comparator enabled
	input wire invert, // Output polarity invert
	input wire [1:0] edge_sel, // Interrupt edge select
	output reg out_r, // Polarised, synchronised output
	output reg event_r // One-cycle interrupt event
);

	reg sync1_r;
	reg sync2_r;
	wire pol_nxt;
	wire rise;
	wire fall;
	reg event_nxt;

	// Two-stage synchroniser, first stage read only by second
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end
		else
		begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
		end
	end

	// Polarity applied; a disabled comparator reads low
	assign pol_nxt = cmp_on & (sync2_r ^ invert);
	assign rise = pol_nxt & ~out_r;
	assign fall = ~pol_nxt & out_r;

	// Edge selection; keeps running whatever the sleep state
	always @*
	begin
		case (edge_sel)
			`CVC_EDGE_NONE: event_nxt = 1'b0;
			`CVC_EDGE_RISE: event_nxt = rise;
			`CVC_EDGE_FALL: event_nxt = fall;
			`CVC_EDGE_ANY: event_nxt = rise | fall;
			default: event_nxt = 1'b0;
		endcase
	end

	// Output and event registers
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_r <= 1'b0;
			event_r <= 1'b0;
		end
		else
		begin
			out_r <= pol_nxt;
			event_r <= event_nxt & cmp_on;
		end
	end

endmodule

// ===== core/cvc_regs.vh
`ifndef CVC_REGS_VH
`define CVC_REGS_VH

// Register byte offsets
`define CVC_OFF_CMP1_CTRL 8'h00
`define CVC_OFF_CMP2_CTRL 8'h04
`define CVC_OFF_CMP_STATUS 8'h08
`define CVC_OFF_SHARED 8'h0C
`define CVC_OFF_WDOG_CTRL 8'h10
`define CVC_OFF_FLAGS 8'h14
`define CVC_OFF_MASK 8'h18

// Decoded register selects
`define CVC_SEL_NONE 3'h0
`define CVC_SEL_CMP1 3'h1
`define CVC_SEL_CMP2 3'h2
`define CVC_SEL_STAT 3'h3
`define CVC_SEL_SHRD 3'h4
`define CVC_SEL_WDOG 3'h5
`define CVC_SEL_FLAG 3'h6
`define CVC_SEL_MASK 3'h7

// Comparator control fields
`define CVC_CMP_ON_BIT 7
`define CVC_CMP_OE_BIT 6
`define CVC_CMP_INV_BIT 5
`define CVC_CMP_EDGE_HI 4
`define CVC_CMP_EDGE_LO 3
`define CVC_CMP_REF_BIT 2
`define CVC_CMP_CH_HI 1
`define CVC_CMP_CH_LO 0

// Edge select encodings
`define CVC_EDGE_NONE 2'h0
`define CVC_EDGE_RISE 2'h1
`define CVC_EDGE_FALL 2'h2
`define CVC_EDGE_ANY 2'h3

// Voltage reference control fields
`define CVC_VREF_ON_BIT 7
`define CVC_VREF_PIN_BIT 6
`define CVC_VREF_RANGE_BIT 5
`define CVC_VREF_SRC_BIT 4
`define CVC_VREF_LVL_HI 3
`define CVC_VREF_LVL_LO 0

// Watchdog control: shared address select
`define CVC_WDOG_SHARED_BIT 4

// Flag and mask layout
`define CVC_FLAG_CMP1_BIT 5
`define CVC_FLAG_CMP2_BIT 6
`define CVC_FLAG_MASK_BITS 8'h60

// Reset values
`define CVC_RST_CMP_CTRL 8'h00
`define CVC_RST_VREF_CTRL 8'h00
`define CVC_RST_TMR4_PERIOD 8'hFF
`define CVC_RST_WDOG_CTRL 8'h00
`define CVC_RST_FLAGS 8'h00
`define CVC_RST_MASK 8'h00

// Bus responses
`define CVC_RESP_OKAY 2'h0
`define CVC_RESP_SLVERR 2'h2

`endif

// ===== core/cvc_top.v
// Functional notes
// - In sleep an enabled comparator keeps running and its interrupt still works.
// - An enabled comparator interrupt during sleep requests wake-up.
// - Wake-up from sleep leaves both comparator control registers unchanged.
// - Reset clears both comparator controls, switching comparators and reference off.
// - Reference control bit 5 selects the output range.
// - Each range has 16 levels set by a 4-bit field, bits 3..0.
// - Range 1: zero base, span/24 steps; range 0: quarter span base, span/32 steps.
// - Bit 4 picks external reference pins (1) or analog supply rails (0).
// - Reference control shares timer 4 period address, visible when shared select set.
// - Pin-drive bit routes reference to port F pin, overriding its direction bit 5.
// - Reset clears reference enable bit 7, disabling the reference.
// - Reset also clears pin-drive, range select and the four level bits.
// - Wake-up by interrupt or watchdog leaves reference control unchanged.
// - Comparator control bit 7 enables or disables that comparator.
// - Status bits 0 and 1 show comparator 1 and 2 outputs, read only.
// - Edge select: 01 rising, 10 falling, 11 any change, 00 never.
// - Interrupt flags at bits 6 and 5 stay set until software clears them.
`timescale 1ns/1ps
`include "cvc_regs.vh"

module cvc_top #(
	parameter ADDR_W = 8 // AXI address width
) (
	input wire MCLK, // System clock, 50 MHz
	input wire ARST_N, // Async reset, active low
	input wire [ADDR_W-1:0] S_AXI_AWADDR, // Write address
	input wire S_AXI_AWVALID, // Write address valid
	output reg S_AXI_AWREADY, // Write address ready
	input wire [31:0] S_AXI_WDATA, // Write data
	input wire [3:0] S_AXI_WSTRB, // Write strobes
	input wire S_AXI_WVALID, // Write data valid
	output reg S_AXI_WREADY, // Write data ready
	output reg [1:0] S_AXI_BRESP, // Write response
	output reg S_AXI_BVALID, // Write response valid
	input wire S_AXI_BREADY, // Write response ready
	input wire [ADDR_W-1:0] S_AXI_ARADDR, // Read address
	input wire S_AXI_ARVALID, // Read address valid
	output reg S_AXI_ARREADY, // Read address ready
	output reg [31:0] S_AXI_RDATA, // Read data
	output reg [1:0] S_AXI_RRESP, // Read response
	output reg S_AXI_RVALID, // Read data valid
	input wire S_AXI_RREADY, // Read data ready
	input wire [1:0] CMP_RAW, // Analog comparator outputs, async
	input wire SLEEP_IN, // Device in sleep, async
	output reg [1:0] CMP_ON, // Comparator enables
	output reg [1:0] CMP_REF_SEL, // Non-inverting reference select
	output reg [1:0] CMP1_CH_SEL, // Comparator 1 inverting input select
	output reg [1:0] CMP2_CH_SEL, // Comparator 2 inverting input select
	output reg [1:0] CMP_PIN_EN, // Comparator output pin enables
	output reg [1:0] CMP_OUT, // Polarised comparator outputs
	output reg VREF_ON, // Reference ladder enabled
	output reg VREF_PIN_DRIVE, // Reference routed to port F pin
	output reg PF5_DIR_OVERRIDE, // Port F bit 5 direction overridden
	output reg VREF_RANGE_SEL, // 1 low range, 0 high range
	output reg VREF_SRC_SEL, // 1 external pins, 0 analog rails
	output reg [3:0] VREF_LEVEL, // Ladder tap select
	output reg [7:0] TMR4_PERIOD, // Timer 4 period value
	output reg IRQ, // Interrupt, active high level
	output reg WAKE_REQ // Wake-up request while sleeping
);

	// Address decode, shared by read and write paths
	function [2:0] dec_sel;
		input [ADDR_W-1:0] addr;
		begin
			case (addr[7:0])
				`CVC_OFF_CMP1_CTRL: dec_sel = `CVC_SEL_CMP1;
				`CVC_OFF_CMP2_CTRL: dec_sel = `CVC_SEL_CMP2;
				`CVC_OFF_CMP_STATUS: dec_sel = `CVC_SEL_STAT;
				`CVC_OFF_SHARED: dec_sel = `CVC_SEL_SHRD;
				`CVC_OFF_WDOG_CTRL: dec_sel = `CVC_SEL_WDOG;
				`CVC_OFF_FLAGS: dec_sel = `CVC_SEL_FLAG;
				`CVC_OFF_MASK: dec_sel = `CVC_SEL_MASK;
				default: dec_sel = `CVC_SEL_NONE;
			endcase
		end
	endfunction

	reg [7:0] cmp_ctrl_r [0:1];
	reg [7:0] vref_ctrl_r;
	reg [7:0] tmr4_r;
	reg [7:0] wdog_r;
	reg [7:0] flags_r;
	reg [7:0] mask_r;
	reg [ADDR_W-1:0] awaddr_r;
	reg aw_held_r;
	reg [7:0] wdata_r;
	reg wstrb0_r;
	reg w_held_r;
	reg slp1_r;
	reg slp2_r;
	wire [1:0] cmp_out;
	wire [1:0] cmp_event;
	wire do_write;
	wire [2:0] wsel;
	wire [2:0] rsel;
	wire wr_en;
	wire shared_sel;
	reg [7:0] rd_byte;
	reg rd_ok;
	reg [7:0] flag_set;
	reg [7:0] flag_clr;
	wire [7:0] flags_nxt;

	// Comparator channels; they run regardless of sleep
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_chan
			cvc_cmp_chan u_chan (
				.clk(MCLK),
				.rst_n(ARST_N),
				.raw_in(CMP_RAW[gi]),
				.cmp_on(cmp_ctrl_r[gi][`CVC_CMP_ON_BIT]),
				.invert(cmp_ctrl_r[gi][`CVC_CMP_INV_BIT]),
				.edge_sel(cmp_ctrl_r[gi][`CVC_CMP_EDGE_HI:`CVC_CMP_EDGE_LO]),
				.out_r(cmp_out[gi]),
				.event_r(cmp_event[gi])
			);
		end
	endgenerate

	// Sleep level synchroniser
	always @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			slp1_r <= 1'b0;
			slp2_r <= 1'b0;
		end
		else
		begin
			slp1_r <= SLEEP_IN;
			slp2_r <= slp1_r;
		end
	end

	// Write channel handshake and capture
	assign do_write = aw_held_r & w_held_r & ~S_AXI_BVALID;
	assign wsel = dec_sel(awaddr_r);
	assign wr_en = do_write & wstrb0_r;
	assign shared_sel = wdog_r[`CVC_WDOG_SHARED_BIT];

	always @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `CVC_RESP_OKAY;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= {ADDR_W{1'b0}};
			wdata_r <= 8'h00;
			wstrb0_r <= 1'b0;
		end
		else
		begin
			S_AXI_AWREADY <= ~aw_held_r & ~(S_AXI_AWVALID & S_AXI_AWREADY) & ~do_write;
			S_AXI_WREADY <= ~w_held_r & ~(S_AXI_WVALID & S_AXI_WREADY) & ~do_write;
			if (S_AXI_AWVALID & S_AXI_AWREADY)
			begin
				aw_held_r <= 1'b1;
				awaddr_r <= S_AXI_AWADDR;
			end
			else if (do_write)
				aw_held_r <= 1'b0;
			if (S_AXI_WVALID & S_AXI_WREADY)
			begin
				w_held_r <= 1'b1;
				wdata_r <= S_AXI_WDATA[7:0];
				wstrb0_r <= S_AXI_WSTRB[0];
			end
			else if (do_write)
				w_held_r <= 1'b0;
			if (do_write)
			begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (wsel == `CVC_SEL_NONE) ? `CVC_RESP_SLVERR : `CVC_RESP_OKAY;
			end
			else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// Control registers; only reset or software writes change them, never wake-up
	always @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			cmp_ctrl_r[0] <= `CVC_RST_CMP_CTRL;
			cmp_ctrl_r[1] <= `CVC_RST_CMP_CTRL;
			vref_ctrl_r <= `CVC_RST_VREF_CTRL;
			tmr4_r <= `CVC_RST_TMR4_PERIOD;
			wdog_r <= `CVC_RST_WDOG_CTRL;
			mask_r <= `CVC_RST_MASK;
		end
		else if (wr_en)
		begin
			case (wsel)
				`CVC_SEL_CMP1: cmp_ctrl_r[0] <= wdata_r;
				`CVC_SEL_CMP2: cmp_ctrl_r[1] <= wdata_r;
				`CVC_SEL_SHRD:
				begin
					if (shared_sel)
						vref_ctrl_r <= wdata_r;
					else
						tmr4_r <= wdata_r;
				end
				`CVC_SEL_WDOG: wdog_r <= wdata_r & 8'h10;
				`CVC_SEL_MASK: mask_r <= wdata_r & `CVC_FLAG_MASK_BITS;
				default: mask_r <= mask_r;
			endcase
		end
	end

	// Flag set and write-one-to-clear terms
	always @*
	begin
		flag_set = 8'h00;
		flag_clr = 8'h00;
		flag_set[`CVC_FLAG_CMP1_BIT] = cmp_event[0];
		flag_set[`CVC_FLAG_CMP2_BIT] = cmp_event[1];
		if (wr_en && (wsel == `CVC_SEL_FLAG))
			flag_clr = wdata_r & `CVC_FLAG_MASK_BITS;
	end

	// Sticky flags, a new event wins over a clear in the same cycle
	assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

	always @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			flags_r <= `CVC_RST_FLAGS;
		else
			flags_r <= flags_nxt;
	end

	// Read channel
	assign rsel = dec_sel(S_AXI_ARADDR);

	always @*
	begin
		rd_ok = 1'b1;
		case (rsel)
			`CVC_SEL_CMP1: rd_byte = cmp_ctrl_r[0];
			`CVC_SEL_CMP2: rd_byte = cmp_ctrl_r[1];
			`CVC_SEL_STAT: rd_byte = {6'h00, cmp_out};
			`CVC_SEL_SHRD: rd_byte = shared_sel ? vref_ctrl_r : tmr4_r;
			`CVC_SEL_WDOG: rd_byte = wdog_r;
			`CVC_SEL_FLAG: rd_byte = flags_r;
			`CVC_SEL_MASK: rd_byte = mask_r;
			default:
			begin
				rd_byte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	always @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `CVC_RESP_OKAY;
		end
		else
		begin
			S_AXI_ARREADY <= ~S_AXI_RVALID & ~(S_AXI_ARVALID & S_AXI_ARREADY);
			if (S_AXI_ARVALID & S_AXI_ARREADY)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= {24'h000000, rd_byte};
				S_AXI_RRESP <= rd_ok ? `CVC_RESP_OKAY : `CVC_RESP_SLVERR;
			end
			else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end

	// Analog-side drive, registered
	always @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			CMP_ON <= 2'h0;
			CMP_REF_SEL <= 2'h0;
			CMP1_CH_SEL <= 2'h0;
			CMP2_CH_SEL <= 2'h0;
			CMP_PIN_EN <= 2'h0;
			CMP_OUT <= 2'h0;
			VREF_ON <= 1'b0;
			VREF_PIN_DRIVE <= 1'b0;
			PF5_DIR_OVERRIDE <= 1'b0;
			VREF_RANGE_SEL <= 1'b0;
			VREF_SRC_SEL <= 1'b0;
			VREF_LEVEL <= 4'h0;
			TMR4_PERIOD <= `CVC_RST_TMR4_PERIOD;
		end
		else
		begin
			CMP_ON <= {cmp_ctrl_r[1][`CVC_CMP_ON_BIT], cmp_ctrl_r[0][`CVC_CMP_ON_BIT]};
			CMP_REF_SEL <= {cmp_ctrl_r[1][`CVC_CMP_REF_BIT], cmp_ctrl_r[0][`CVC_CMP_REF_BIT]};
			CMP1_CH_SEL <= cmp_ctrl_r[0][`CVC_CMP_CH_HI:`CVC_CMP_CH_LO];
			CMP2_CH_SEL <= cmp_ctrl_r[1][`CVC_CMP_CH_HI:`CVC_CMP_CH_LO];
			CMP_PIN_EN <= {cmp_ctrl_r[1][`CVC_CMP_OE_BIT], cmp_ctrl_r[0][`CVC_CMP_OE_BIT]};
			CMP_OUT <= cmp_out;
			VREF_ON <= vref_ctrl_r[`CVC_VREF_ON_BIT];
			VREF_PIN_DRIVE <= vref_ctrl_r[`CVC_VREF_PIN_BIT];
			PF5_DIR_OVERRIDE <= vref_ctrl_r[`CVC_VREF_PIN_BIT];
			VREF_RANGE_SEL <= vref_ctrl_r[`CVC_VREF_RANGE_BIT];
			VREF_SRC_SEL <= vref_ctrl_r[`CVC_VREF_SRC_BIT];
			VREF_LEVEL <= vref_ctrl_r[`CVC_VREF_LVL_HI:`CVC_VREF_LVL_LO];
			TMR4_PERIOD <= tmr4_r;
		end
	end

	// Interrupt and wake request from unmasked flags
	always @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			IRQ <= 1'b0;
			WAKE_REQ <= 1'b0;
		end
		else
		begin
			IRQ <= |(flags_r & mask_r);
			WAKE_REQ <= slp2_r & (|(flags_r & mask_r));
		end
	end

endmodule

// ===== verification/cvc_analog_model.sv
`timescale 1ns/1ps
// Analog side: ladder tap compared with a test input per comparator
module cvc_analog_model (
	input wire clk, // System clock
	input wire [1:0] cmp_on, // Comparator enables
	input wire vref_on, // Ladder enabled
	input wire range_sel, // Ladder range select
	input wire [3:0] level, // Ladder tap
	input wire [13:0] vin, // Test inputs in 96ths of span
	output reg [1:0] raw // Comparator outputs
);
	// Tap in 96ths: low range steps of 4, high range 24 plus steps of 3
	wire [6:0] ref_lvl = range_sel ? {1'b0, level, 2'b00} : 7'h18 + {3'h0, level} * 7'h03;
	initial raw = 2'h0;
	// Switched-off comparators show a toggling output
	always @(posedge clk)
	begin
		raw[0] <= (cmp_on[0] === 1'b1 && vref_on === 1'b1) ? (vin[6:0] > ref_lvl) : ~raw[0];
		raw[1] <= (cmp_on[1] === 1'b1 && vref_on === 1'b1) ? (vin[13:7] > ref_lvl) : ~raw[1];
	end
endmodule

// ===== verification/cvc_top_monitor.sv
`timescale 1ns/1ps
// Port checks for the comparator and reference control block
module cvc_top_monitor (
	input wire MCLK, // System clock
	input wire ARST_N, // Reset, active low
	input wire S_AXI_AWVALID, // Write address valid
	input wire S_AXI_AWREADY, // Write address ready
	input wire S_AXI_WVALID, // Write data valid
	input wire S_AXI_WREADY, // Write data ready
	input wire S_AXI_BVALID, // Write response valid
	input wire S_AXI_ARVALID, // Read address valid
	input wire S_AXI_ARREADY, // Read address ready
	input wire S_AXI_RVALID, // Read data valid
	input wire [1:0] CMP_ON, // Comparator enables
	input wire [1:0] CMP_OUT, // Comparator outputs
	input wire VREF_ON, // Ladder enabled
	input wire VREF_PIN_DRIVE, // Reference on pin
	input wire PF5_DIR_OVERRIDE, // Pin direction override
	input wire VREF_RANGE_SEL, // Range select
	input wire VREF_SRC_SEL, // Source select
	input wire [3:0] VREF_LEVEL, // Ladder tap
	input wire [7:0] TMR4_PERIOD, // Timer period
	input wire IRQ, // Interrupt
	input wire WAKE_REQ // Wake-up request
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	// Reference control as one byte
	wire [7:0] vref_w = {VREF_ON, VREF_PIN_DRIVE, VREF_RANGE_SEL, VREF_SRC_SEL, VREF_LEVEL};
	// Write steps: both halves taken, then the answer
	sequence wr_pair;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence resp_due;
		##2 S_AXI_BVALID;
	endsequence
	wr_resp_a: assert property (wr_pair |-> resp_due) else $error("write answer late");
	rd_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read late");
	rst_clear_a: assert property ($rose(ARST_N) |-> vref_w == 8'h00 && CMP_ON == 2'h0)
		else $error("reset values wrong");
	// Control outputs move only one cycle after a write answer
	ctrl_hold_a: assert property ($past(ARST_N) && ($changed(vref_w) || $changed(CMP_ON)
		|| $changed(TMR4_PERIOD)) |-> $past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2))
		else $error("control changed without write");
	pin_ovr_a: assert property (PF5_DIR_OVERRIDE == VREF_PIN_DRIVE) else $error("pin override wrong");
	off_quiet_a: assert property ((CMP_OUT & ~CMP_ON & ~$past(CMP_ON)) == 2'h0)
		else $error("off comparator output high");
	irq_cause_a: assert property ($rose(IRQ) |-> $past(CMP_OUT) != $past(CMP_OUT, 2) || $past(S_AXI_BVALID))
		else $error("interrupt without cause");
	irq_sticky_a: assert property ($fell(IRQ) |-> $past(S_AXI_BVALID)) else $error("flag lost");
	wake_irq_a: assert property (WAKE_REQ |-> IRQ) else $error("wake without interrupt");
endmodule
bind cvc_top cvc_top_monitor mon_u (.MCLK, .ARST_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
	.S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .CMP_ON, .CMP_OUT, .VREF_ON, .VREF_PIN_DRIVE,
	.PF5_DIR_OVERRIDE, .VREF_RANGE_SEL, .VREF_SRC_SEL, .VREF_LEVEL, .TMR4_PERIOD, .IRQ, .WAKE_REQ);

// ===== verification/tb_top.sv
`timescale 1ns/1ps
// Register bus stimulus with queued expectations
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, slp = 1'b0;
	logic [13:0] vin = 14'h0;
	wire awr, wr, bv, arr, rv, irq, wk, vo, vp, pf, vr, vs;
	wire [1:0] bre, rre, raw, comparator_on, noninverting_ref_select, c1, c2, cpe, cout;
	wire [31:0] rd;
	wire [3:0] lvl;
	wire [7:0] tp;
	logic [33:0] eq[$];
	int fails = 0, checks_done = 0, seed = 32'h301e7957;
	cvc_top dut_u (.MCLK(clk), .ARST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bre),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rd), .S_AXI_RRESP(rre), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .CMP_RAW(raw), .SLEEP_IN(slp),
		.CMP_ON(comparator_on), .CMP_REF_SEL(noninverting_ref_select), .CMP1_CH_SEL(c1), .CMP2_CH_SEL(c2), .CMP_PIN_EN(cpe), .CMP_OUT(cout),
		.VREF_ON(vo), .VREF_PIN_DRIVE(vp), .PF5_DIR_OVERRIDE(pf), .VREF_RANGE_SEL(vr), .VREF_SRC_SEL(vs),
		.VREF_LEVEL(lvl), .TMR4_PERIOD(tp), .IRQ(irq), .WAKE_REQ(wk));
	cvc_analog_model ana_u (.clk(clk), .cmp_on(comparator_on), .vref_on(vo), .range_sel(vr), .level(lvl), .vin(vin),
		.raw(raw));
	// Clock, 20 ns period
	initial
	begin
		forever #10 clk = ~clk;
	end
	task automatic complete_run;
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Bus write, expected response noted first
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		eq.push_back({e, 32'h0});
		@(posedge clk);
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
		end
		while (!bv);
		br <= 1'b0;
		// Registered outputs settle after the write edge
		@(negedge clk);
	endtask
	// Bus read, expected answer noted first
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		eq.push_back({e, 24'h0, d});
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
		end
		while (!rv);
		rr <= 1'b0;
	endtask
	// Compare each bus answer with the oldest note
	always @(posedge clk)
		if ((bv && br) || (rv && rr))
			chk(bv ? {bre, 32'h0} : {rre, rd}, eq.pop_front());
	// Cut a hang short
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		complete_run();
	end
	// Main sequence
	initial
	begin
		logic [7:0] v;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n <= 1'b1;
		rd_reg(8'h00, 8'h00, 2'h0);
		rd_reg(8'h04, 8'h00, 2'h0);
		rd_reg(8'h0C, 8'hFF, 2'h0);
		wr_reg(8'h10, 8'h10, 2'h0);
		rd_reg(8'h0C, 8'h00, 2'h0);
		repeat (4)
		begin
			v = $random(seed);
			wr_reg(8'h0C, v, 2'h0);
			chk({25'h0, vo, vp, vr, vs, lvl, pf}, {25'h0, v, v[6]});
			rd_reg(8'h0C, v, 2'h0);
		end
		wr_reg(8'h10, 8'h00, 2'h0);
		wr_reg(8'h0C, 8'h5A, 2'h0);
		chk({18'h0, tp, vo, vp, vr, vs, lvl}, {18'h0, 8'h5A, v});
		wr_reg(8'h10, 8'h10, 2'h0);
		wr_reg(8'h0C, 8'hA6, 2'h0);
		wr_reg(8'h18, 8'h60, 2'h0);
		wr_reg(8'h04, 8'h47, 2'h0);
		chk({30'h0, cpe[1], noninverting_ref_select[1], c2}, {30'h0, 4'hF});
		for (int es = 0; es < 4; es++)
		begin
			wr_reg(8'h00, 8'h80 | {3'h0, es[1:0], 3'h0}, 2'h0);
			repeat (8) @(posedge clk);
			wr_reg(8'h14, 8'h60, 2'h0);
			vin[6:0] <= 7'd40;
			repeat (8) @(posedge clk);
			rd_reg(8'h08, 8'h01, 2'h0);
			rd_reg(8'h14, es[0] ? 8'h20 : 8'h00, 2'h0);
			chk({33'h0, irq}, {33'h0, es[0]});
			wr_reg(8'h14, 8'h60, 2'h0);
			vin[6:0] <= 7'd10;
			repeat (8) @(posedge clk);
			rd_reg(8'h14, es[1] ? 8'h20 : 8'h00, 2'h0);
			wr_reg(8'h14, 8'h60, 2'h0);
		end
		slp <= 1'b1;
		vin[6:0] <= 7'd40;
		repeat (8) @(posedge clk);
		chk({32'h0, irq, wk}, {32'h0, 2'h3});
		wr_reg(8'h18, 8'h00, 2'h0);
		chk({32'h0, irq, wk}, 34'h0);
		slp <= 1'b0;
		rd_reg(8'h00, 8'h98, 2'h0);
		rd_reg(8'h0C, 8'hA6, 2'h0);
		rd_reg(8'h14, 8'h20, 2'h0);
		wr_reg(8'h08, 8'hFF, 2'h0);
		rd_reg(8'h08, 8'h01, 2'h0);
		wr_reg(8'h00, 8'hB8, 2'h0);
		rd_reg(8'h08, 8'h00, 2'h0);
		wr_reg(8'h1C, 8'h55, 2'h2);
		rd_reg(8'h1C, 8'h00, 2'h2);
		wr_reg(8'h00, 8'h47, 2'h0);
		chk({30'h0, cpe[0], noninverting_ref_select[0], c1}, {30'h0, 4'hF});
		rst_n <= 1'b0;
		@(posedge clk);
		chk({8'h0, cpe, noninverting_ref_select, c1, c2, comparator_on, vo, vp, vr, vs, lvl, tp}, {26'h0, 8'hFF});
		@(negedge clk);
		rst_n <= 1'b1;
		rd_reg(8'h04, 8'h00, 2'h0);
		complete_run();
	end
endmodule
